// [hdl/fsrp_host.sv]
// Contract
// - Reset during busy: ready low up to 20 us; host watches or waits.
// - Host waits 50 ns after reset release before valid reads; the code waits only after a reset order, not when leaving power-down.
// - After reset during busy, affected locations must be rewritten.
// - Protect: pin pattern, high voltage, 100 us write-strobe pulse per sector.
// - Protect all sectors first; then 10 ms pulse unprotects all.
//
// The implementer's own choices: the register offsets and register access over Wishbone.
`timescale 1ns/1ps
module fsrp_host #(
  parameter int unsigned PROT_CYC = fsrp_pkg::PROT_CYC,
  parameter int unsigned UNPR_CYC = fsrp_pkg::UNPR_CYC
) (
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic        ce,
  input  wire logic        wb_cyc,
  input  wire logic        wb_stb,
  input  wire logic        wb_we,
  input  wire logic [7:0]  wb_adr,
  input  wire logic [3:0]  wb_sel,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack,
  output logic      [19:0] fl_addr,
  output logic      [7:0]  fl_dq_o,
  output logic             fl_dq_oe_n,
  input  wire logic [7:0]  fl_dq_i,
  output logic             fl_ce_n,
  output logic             fl_oe_n,
  output logic             fl_we_n,
  output logic             fl_reset_n,
  output logic             fl_a9_hv_en,
  output logic             fl_oe_hv_en,
  output logic             fl_rst_hv_en,
  input  wire logic        fl_ready_busy,
  input  wire logic        supply_ok
);
  import fsrp_pkg::*;

  localparam int TW = TMR_W;

  fsrp_state_t  state_q, state_d;
  fsrp_op_t     op_q;
  logic [19:0]  addr_q;
  logic [7:0]   wdata_q, rdata_q, susp_q;
  logic         pdown_q, tmpunp_q;
  logic         done_q, refused_q, rewrite_q;
  logic         busy_at_rst_q;
  logic [6:0]   walk_q;
  logic         walk_end_q;
  logic [31:0]  rd_q;
  logic         ack_q;

  // pins from flops
  logic [19:0]  addr_pin_d;
  logic         ce_pin_d, oe_pin_d, we_pin_d, dq_oe_n_d, rst_pin_d;
  logic         a9hv_d, oehv_d, rsthv_d;

  // synchronised pin inputs
  logic [7:0]   dq_s;
  logic         rb_s, supply_s;

  fsrp_sync #(.W(8)) u_sync_dq (
    .clk  (clk),
    .rstn (rstn),
    .ce   (ce),
    .d    (fl_dq_i),
    .q    (dq_s)
  );
  fsrp_sync #(.W(2)) u_sync_ctl (
    .clk  (clk),
    .rstn (rstn),
    .ce   (ce),
    .d    ({fl_ready_busy, supply_ok}),
    .q    ({rb_s, supply_s})
  );

  fsrp_tmr_if #(.TW(TW)) seq_t ();
  fsrp_tmr_if #(.TW(TW)) blank_t ();

  fsrp_timer #(.TW(TW)) u_seq_tmr (
    .clk  (clk),
    .rstn (rstn),
    .ce   (ce),
    .t    (seq_t)
  );
  fsrp_timer #(.TW(TW)) u_blank_tmr (
    .clk  (clk),
    .rstn (rstn),
    .ce   (ce),
    .t    (blank_t)
  );

  // wishbone decode
  wire        wb_req   = wb_cyc & wb_stb;
  wire        wb_wr    = wb_req & wb_we & ack_q;
  wire [31:0] wmask    = {{8{wb_sel[3]}}, {8{wb_sel[2]}}, {8{wb_sel[1]}}, {8{wb_sel[0]}}};
  wire        hit_ctrl = (wb_adr == REG_CTRL);
  wire        hit_addr = (wb_adr == REG_ADDR);
  wire        hit_wdat = (wb_adr == REG_WDATA);
  wire        hit_stat = (wb_adr == REG_STATUS);
  wire        hit_mode = (wb_adr == REG_MODE);
  wire        go       = wb_wr & hit_ctrl & wb_sel[0] & wb_dat_i[CTRL_GO];
  wire [2:0]  go_op    = wb_dat_i[CTRL_OP_LSB +: 3];
  wire [31:0] stat_clr = (wb_wr & hit_stat) ? (wb_dat_i & wmask) : 32'h0;

  // op classes
  wire is_rdop   = (op_q == OP_READ) | (op_q == OP_VPROT) | (op_q == OP_VUNPROT);
  wire is_write  = (op_q == OP_WRITE);
  wire is_hvprog = (op_q == OP_PROTECT) | (op_q == OP_UNPROT);
  wire is_verify = (op_q == OP_VPROT) | (op_q == OP_VUNPROT);
  wire unp_pulse = (op_q == OP_UNPROT) & walk_end_q;
  wire in_seq    = (state_q == S_SETUP) | (state_q == S_PULSE);
  wire rst_seq   = (state_q == S_RSTLO) | (state_q == S_RSTWT) | (state_q == S_RSTREC);
  // strobe rises while chip-select, data and high voltage still stand, never in the same edge
  wire in_cyc    = in_seq | (state_q == S_RECOV);

  // device busy only counts once the busy delay after a write strobe has run
  wire rb_valid  = blank_t.done;
  wire dev_busy  = rb_valid & ~rb_s;

  // refusal of a new order
  wire go_rd     = (go_op == OP_READ) | (go_op == OP_VPROT) | (go_op == OP_VUNPROT);
  wire go_cmdwr  = (go_op == OP_WRITE);
  wire go_hv     = (go_op == OP_PROTECT) | (go_op == OP_UNPROT);
  wire wdat_susp = (wdata_q == susp_q);
  wire refuse_wr = go_cmdwr & (~supply_s | (dev_busy & ~wdat_susp));
  wire refuse_hv = (go_hv | (go_op > OP_VUNPROT)) & (dev_busy | pdown_q);
  wire refuse_rd = go_rd & pdown_q;
  wire accept    = go & (state_q == S_IDLE) & ~refuse_wr & ~refuse_hv & ~refuse_rd;
  wire refuse    = go & ~accept;

  // sequencer
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      S_IDLE: begin
        if (accept) begin
          state_d = (go_op == OP_RESET) ? S_RSTLO : S_SETUP;
        end
      end
      S_SETUP: begin
        if (seq_t.done) begin
          state_d = S_PULSE;
        end
      end
      S_PULSE: begin
        if (seq_t.done) begin
          state_d = S_RECOV;
        end
      end
      S_RECOV: begin
        if (seq_t.done) begin
          state_d = ((op_q == OP_UNPROT) & ~unp_pulse) ? S_SETUP : S_IDLE;
        end
      end
      S_RSTLO: begin
        if (seq_t.done) begin
          state_d = S_RSTWT;
        end
      end
      S_RSTWT: begin
        if (seq_t.done | (busy_at_rst_q & rb_s)) begin
          state_d = S_RSTREC;
        end
      end
      S_RSTREC: begin
        if (seq_t.done) begin
          state_d = S_IDLE;
        end
      end
      default: state_d = S_IDLE;
    endcase
  end

  // timer load on every state entry
  always_comb begin
    seq_t.start = (state_d != state_q);
    seq_t.val   = '0;
    unique case (state_d)
      S_SETUP:  seq_t.val = (is_hvprog | is_verify | go_hv | (go_op > OP_RESET)) ? TW'(HV_SETUP_CYC) : TW'(1);
      S_PULSE: begin
        if (is_rdop) begin
          seq_t.val = TW'(ACCESS_CYC);
        end else if (unp_pulse) begin
          seq_t.val = TW'(UNPR_CYC);
        end else if (is_hvprog) begin
          seq_t.val = TW'(PROT_CYC);
        end else begin
          seq_t.val = TW'(WE_LOW_CYC);
        end
      end
      S_RECOV:  seq_t.val = TW'(RECOV_CYC);
      S_RSTLO:  seq_t.val = TW'(RST_LOW_CYC);
      S_RSTWT:  seq_t.val = busy_at_rst_q ? TW'(RST_BUSY_CYC) : TW'(RST_READ_CYC);
      S_RSTREC: seq_t.val = TW'(RST_REC_CYC);
      S_IDLE:   seq_t.val = '0;
      default:  seq_t.val = '0;
    endcase
  end

  wire pulse_end = (state_q == S_PULSE) & seq_t.done;
  assign blank_t.start = pulse_end & is_write;
  assign blank_t.val   = TW'(BUSY_VAL_CYC);

  // pin values, registered below
  wire [6:0] sect_d = (op_q == OP_UNPROT) ? walk_q : addr_q[19:A_SEC_LSB];
  wire       six_d  = (op_q == OP_VUNPROT) | unp_pulse;
  wire [19:0] hv_addr = {sect_d, 13'h0} | (20'h1 << A_ONE) | (20'(six_d) << A_SIX);
  assign addr_pin_d = (is_hvprog | is_verify) ? hv_addr : addr_q;
  assign ce_pin_d   = ~in_cyc;
  assign oe_pin_d   = ~((state_q == S_PULSE) & is_rdop) | is_hvprog;
  assign we_pin_d   = ~((state_q == S_PULSE) & (is_write | is_hvprog));
  assign dq_oe_n_d  = ~(in_cyc & is_write) | rst_seq;
  assign a9hv_d     = in_cyc & (is_hvprog | is_verify);
  assign oehv_d     = in_cyc & is_hvprog;
  assign rst_pin_d  = ~((state_q == S_RSTLO) | (pdown_q & (state_q == S_IDLE)));
  assign rsthv_d    = tmpunp_q & rst_pin_d & ~rst_seq;

  // strobes reset high so nothing looks like a write at power-up
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      fl_addr      <= 20'h0;
      fl_dq_o      <= 8'h0;
      fl_dq_oe_n   <= 1'b1;
      fl_ce_n      <= 1'b1;
      fl_oe_n      <= 1'b1;
      fl_we_n      <= 1'b1;
      fl_reset_n   <= 1'b1;
      fl_a9_hv_en  <= 1'b0;
      fl_oe_hv_en  <= 1'b0;
      fl_rst_hv_en <= 1'b0;
    end else if (ce) begin
      fl_addr      <= addr_pin_d;
      fl_dq_o      <= wdata_q;
      fl_dq_oe_n   <= dq_oe_n_d;
      fl_ce_n      <= ce_pin_d;
      fl_oe_n      <= oe_pin_d;
      fl_we_n      <= we_pin_d;
      fl_reset_n   <= rst_pin_d;
      fl_a9_hv_en  <= a9hv_d;
      fl_oe_hv_en  <= oehv_d;
      fl_rst_hv_en <= rsthv_d;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_q       <= S_IDLE;
      op_q          <= OP_READ;
      busy_at_rst_q <= 1'b0;
      walk_q        <= 7'h0;
      walk_end_q    <= 1'b0;
      rdata_q       <= 8'h0;
    end else if (ce) begin
      state_q <= state_d;
      if (accept) begin
        op_q          <= fsrp_op_t'(go_op);
        busy_at_rst_q <= dev_busy;
        walk_q        <= 7'h0;
        walk_end_q    <= 1'b0;
      end
      // every sector code is protected before the unprotect pulse
      if ((state_q == S_RECOV) & seq_t.done & (op_q == OP_UNPROT) & ~walk_end_q) begin
        walk_q     <= walk_q + 7'h1;
        walk_end_q <= (walk_q == 7'h7f);
      end
      if (pulse_end & is_rdop) begin
        rdata_q <= dq_s;
      end
    end
  end

  // software registers; sticky flags: set wins over clear
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      addr_q    <= 20'h0;
      wdata_q   <= 8'h0;
      susp_q    <= SUSP_RST;
      pdown_q   <= 1'b0;
      tmpunp_q  <= 1'b0;
      done_q    <= 1'b0;
      refused_q <= 1'b0;
      rewrite_q <= 1'b0;
    end else if (ce) begin
      if (wb_wr & hit_addr) begin
        addr_q <= (addr_q & wmask[19:0]) ^ addr_q ^ (wb_dat_i[19:0] & wmask[19:0]);
      end
      if (wb_wr & hit_wdat & wb_sel[0] & (state_q == S_IDLE)) begin
        wdata_q <= wb_dat_i[7:0];
      end
      if (wb_wr & hit_mode & wb_sel[0]) begin
        pdown_q  <= wb_dat_i[MODE_PDOWN];
        tmpunp_q <= wb_dat_i[MODE_TMPUNP];
      end
      if (wb_wr & hit_mode & wb_sel[1]) begin
        susp_q <= wb_dat_i[MODE_SUSP_LSB +: 8];
      end
      done_q    <= ((state_q != S_IDLE) & (state_d == S_IDLE)) | (done_q & ~stat_clr[ST_DONE]);
      refused_q <= refuse | (refused_q & ~stat_clr[ST_REFUSED]);
      // contents near an interrupted program or erase are suspect
      rewrite_q <= (accept & (go_op == OP_RESET) & dev_busy) | (rewrite_q & ~stat_clr[ST_REWRITE]);
    end
  end

  // read mux, registered in the request cycle
  wire [31:0] stat_w = {24'h0, (rdata_q == PROT_YES), supply_s, rewrite_q, refused_q,
                        done_q, rb_valid, rb_s, (state_q != S_IDLE)};
  wire [31:0] mode_w = {16'h0, susp_q, 6'h0, tmpunp_q, pdown_q};
  wire [31:0] rd_mux = hit_ctrl ? {28'h0, op_q, 1'b0} :
                       hit_addr ? {12'h0, addr_q} :
                       hit_wdat ? {24'h0, wdata_q} :
                       (wb_adr == REG_RDATA) ? {24'h0, rdata_q} :
                       hit_stat ? stat_w :
                       hit_mode ? mode_w : 32'h0;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ack_q <= 1'b0;
      rd_q  <= 32'h0;
    end else if (ce) begin
      ack_q <= wb_req & ~ack_q;
      if (wb_req & ~ack_q) begin
        rd_q <= rd_mux;
      end
    end
  end

  assign wb_ack   = ack_q;
  assign wb_dat_o = rd_q;
endmodule

// [hdl/fsrp_pkg.sv]
package fsrp_pkg;
  localparam int CLK_NS          = 8;
  localparam int TMR_W           = 21;
  // register byte offsets
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_ADDR   = 8'h04;
  localparam logic [7:0] REG_WDATA  = 8'h08;
  localparam logic [7:0] REG_RDATA  = 8'h0c;
  localparam logic [7:0] REG_STATUS = 8'h10;
  localparam logic [7:0] REG_MODE   = 8'h14;
  // ctrl fields
  localparam int CTRL_GO       = 0;
  localparam int CTRL_OP_LSB   = 1;
  // status fields
  localparam int ST_CBUSY      = 0;
  localparam int ST_READY      = 1;
  localparam int ST_RBVALID    = 2;
  localparam int ST_DONE       = 3;
  localparam int ST_REFUSED    = 4;
  localparam int ST_REWRITE    = 5;
  localparam int ST_SUPPLY     = 6;
  localparam int ST_PROT       = 7;
  // mode fields, their reset value and the protected read code
  localparam int MODE_PDOWN    = 0;
  localparam int MODE_TMPUNP   = 1;
  localparam int MODE_SUSP_LSB = 8;
  localparam logic [7:0] SUSP_RST = 8'hb0;
  localparam logic [7:0] PROT_YES = 8'h01;
  // pin-mode address bits
  localparam int A_SEC_LSB     = 13;
  localparam int A_SIX         = 6;
  localparam int A_ONE         = 1;
  // times in their own units
  localparam int RST_LOW_NS    = 500;
  localparam int RST_BUSY_US   = 20;
  localparam int RST_READ_NS   = 500;
  localparam int RST_REC_NS    = 50;
  localparam int PROT_PULSE_US = 100;
  localparam int UNPR_PULSE_MS = 10;
  localparam int WE_LOW_NS     = 50;
  localparam int ACCESS_NS     = 120;
  localparam int RECOV_NS      = 50;
  localparam int HV_SETUP_NS   = 1000;
  localparam int BUSY_VALID_NS = 90;
  // cycle counts, least times rounded up
  localparam int RST_LOW_CYC   = (RST_LOW_NS + CLK_NS - 1) / CLK_NS;
  localparam int RST_BUSY_CYC  = (RST_BUSY_US * 1000 + CLK_NS - 1) / CLK_NS;
  localparam int RST_READ_CYC  = (RST_READ_NS + CLK_NS - 1) / CLK_NS;
  localparam int RST_REC_CYC   = (RST_REC_NS + CLK_NS - 1) / CLK_NS;
  localparam int PROT_CYC      = (PROT_PULSE_US * 1000 + CLK_NS - 1) / CLK_NS;
  localparam int UNPR_CYC      = (UNPR_PULSE_MS * 1000000 + CLK_NS - 1) / CLK_NS;
  localparam int WE_LOW_CYC    = (WE_LOW_NS + CLK_NS - 1) / CLK_NS;
  localparam int ACCESS_CYC    = (ACCESS_NS + CLK_NS - 1) / CLK_NS + 2;
  localparam int RECOV_CYC     = (RECOV_NS + CLK_NS - 1) / CLK_NS;
  localparam int HV_SETUP_CYC  = (HV_SETUP_NS + CLK_NS - 1) / CLK_NS;
  localparam int BUSY_VAL_CYC  = (BUSY_VALID_NS + CLK_NS - 1) / CLK_NS;

  typedef enum logic [2:0] {
    OP_READ    = 3'h0,
    OP_WRITE   = 3'h1,
    OP_RESET   = 3'h2,
    OP_PROTECT = 3'h3,
    OP_UNPROT  = 3'h4,
    OP_VPROT   = 3'h5,
    OP_VUNPROT = 3'h6
  } fsrp_op_t;

  typedef enum logic [6:0] {
    S_IDLE   = 7'h01,
    S_SETUP  = 7'h02,
    S_PULSE  = 7'h04,
    S_RECOV  = 7'h08,
    S_RSTLO  = 7'h10,
    S_RSTWT  = 7'h20,
    S_RSTREC = 7'h40
  } fsrp_state_t;
endpackage

// [hdl/fsrp_sync.sv]
`timescale 1ns/1ps
module fsrp_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rstn,
  input  wire logic         ce,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_q;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      meta_q <= '0;
      q      <= '0;
    end else if (ce) begin
      meta_q <= d;
      q      <= meta_q;
    end
  end
endmodule

// [hdl/fsrp_timer.sv]
`timescale 1ns/1ps
module fsrp_timer #(
  parameter int TW = 21
) (
  input  wire logic clk,
  input  wire logic rstn,
  input  wire logic ce,
  fsrp_tmr_if.tmr   t
);
  logic [TW-1:0] cnt_q;

  // done is a level: the loaded count has run out
  assign t.done = (cnt_q == '0);

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cnt_q <= '0;
    end else if (ce) begin
      if (t.start) begin
        cnt_q <= t.val;
      end else if (cnt_q != '0) begin
        cnt_q <= cnt_q - 1'b1;
      end
    end
  end
endmodule

// [hdl/fsrp_tmr_if.sv]
`timescale 1ns/1ps
interface fsrp_tmr_if #(parameter int TW = 21);
  logic          start;
  logic [TW-1:0] val;
  logic          done;
  modport ctl (output start, output val, input done);
  modport tmr (input start, input val, output done);
endinterface

// [testbench/fsrp_flash_model.sv]
`timescale 1ns/1ps
module fsrp_flash_model #(
  parameter int BUSY_NS = 800,
  parameter int PROT_NS = 100000,
  parameter int UNPR_NS = 10000000
) (
  input wire logic [19:0] fl_addr,
  input wire logic [7:0]  fl_dq_o,
  input wire logic        fl_dq_oe_n,
  input wire logic        fl_ce_n,
  input wire logic        fl_oe_n,
  input wire logic        fl_we_n,
  input wire logic        fl_reset_n,
  input wire logic        fl_a9_hv_en,
  input wire logic        fl_oe_hv_en,
  input wire logic        fl_rst_hv_en,
  input wire logic        supply_ok,
  output logic      [7:0] fl_dq_i,
  output logic            fl_ready_busy
);
  // only 4k cells, so addresses alias on the low 12 bits
  logic [7:0]   mem [4096] = '{default: 8'hff};
  logic [127:0] prot = '0;
  logic [7:0]   last = 8'h00;
  logic         busy = 1'b0;
  logic         was_busy = 1'b0;
  int           gen = 0;
  realtime      t_fall = 0;
  wire  [6:0]   sec = fl_addr[19:13];
  wire          vfy = fl_a9_hv_en & fl_addr[1] & !fl_addr[0];
  wire          rd_en = fl_reset_n & !fl_ce_n & !fl_oe_n;
  assign fl_ready_busy = !busy;
  assign fl_dq_i = rd_en ? (vfy ? {7'h0, prot[sec]} : mem[fl_addr[11:0]]) :
                   (!fl_dq_oe_n ? fl_dq_o : ~last);
  always @(fl_dq_i) if (rd_en || !fl_dq_oe_n) last = fl_dq_i;
  task automatic run(input int d0, input int len);
    int g;
    g = ++gen;
    #(d0);
    if (g == gen) busy = 1'b1;
    #(len);
    if (g == gen) busy = 1'b0;
  endtask
  always @(negedge fl_we_n) t_fall = $realtime;
  always @(posedge fl_we_n) begin
    if (!fl_ce_n && $realtime - t_fall >= 5) begin
      if (fl_a9_hv_en && fl_oe_hv_en && fl_addr[1] && !fl_addr[0]) begin
        if (!fl_addr[6] && $realtime - t_fall >= PROT_NS) prot[sec] = 1'b1;
        if (fl_addr[6] && &prot && $realtime - t_fall >= UNPR_NS) prot = '0;
      end else if (busy && fl_oe_n && fl_dq_o == fsrp_pkg::SUSP_RST) begin
        gen++;
        busy = 1'b0;
      end else if (fl_oe_n && fl_reset_n && supply_ok && !busy) begin
        if (!prot[sec] || fl_rst_hv_en) mem[fl_addr[11:0]] = fl_dq_o;
        fork
          run(80, BUSY_NS);
        join_none
      end
    end
  end
  always @(negedge fl_reset_n) begin
    was_busy = busy;
    gen++;
  end
  always @(posedge fl_reset_n) begin
    if (was_busy) begin
      fork
        run(0, 1000);
      join_none
    end
  end
endmodule

// [testbench/fsrp_host_chk.sv]
`timescale 1ns/1ps
module fsrp_host_chk #(
  parameter int unsigned PROT_CYC = 12500,
  parameter int unsigned UNPR_CYC = 1250000
) (
  input wire logic        clk,
  input wire logic        rstn,
  input wire logic        wb_cyc,
  input wire logic        wb_stb,
  input wire logic        wb_ack,
  input wire logic [19:0] fl_addr,
  input wire logic        fl_dq_oe_n,
  input wire logic        fl_ce_n,
  input wire logic        fl_oe_n,
  input wire logic        fl_we_n,
  input wire logic        fl_reset_n,
  input wire logic        fl_a9_hv_en,
  input wire logic        fl_oe_hv_en
);
  // cycles of the current write-strobe low phase; too short a pulse leaves a sector half done
  logic [31:0] lo_q;
  logic [31:0] lo_d;
  wire         pin_wr = fl_a9_hv_en & fl_oe_hv_en & !fl_we_n;
  assign lo_d = fl_we_n ? 32'h0 : lo_q + 32'h1;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) lo_q <= 32'h0;
    else lo_q <= lo_d;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  property p_ack; wb_cyc && wb_stb && !wb_ack |=> wb_ack; endproperty
  a_ack: assert property (p_ack) else $error("request not answered in one cycle");
  property p_ack_once; wb_ack |=> !wb_ack; endproperty
  a_ack_once: assert property (p_ack_once) else $error("ack held over one cycle");
  property p_prot_pins; pin_wr && !fl_addr[6] |-> !fl_ce_n && !fl_addr[0] && fl_addr[1]; endproperty
  a_prot_pins: assert property (p_prot_pins) else $error("bad protect pin pattern");
  property p_unpr_pins; pin_wr && fl_addr[6] |-> !fl_ce_n && !fl_addr[0] && fl_addr[1]; endproperty
  a_unpr_pins: assert property (p_unpr_pins) else $error("bad unprotect pin pattern");
  property p_prot_len; $rose(fl_we_n) && fl_a9_hv_en && !fl_addr[6] |-> lo_q >= PROT_CYC; endproperty
  a_prot_len: assert property (p_prot_len) else $error("protect pulse too short");
  property p_unpr_len; $rose(fl_we_n) && fl_a9_hv_en && fl_addr[6] |-> lo_q >= UNPR_CYC; endproperty
  a_unpr_len: assert property (p_unpr_len) else $error("unprotect pulse too short");
  property p_rec; $rose(fl_reset_n) |-> fl_oe_n [*7]; endproperty
  a_rec: assert property (p_rec) else $error("read too soon after reset");
  property p_hv_oe; fl_oe_hv_en |-> fl_oe_n; endproperty
  a_hv_oe: assert property (p_hv_oe) else $error("output enable low under high voltage");
  property p_dq; !fl_dq_oe_n |-> fl_oe_n && fl_reset_n; endproperty
  a_dq: assert property (p_dq) else $error("data bus contention");
  c_prot: cover property (pin_wr && !fl_addr[6]);
  c_unpr: cover property (pin_wr && fl_addr[6]);
  c_rst: cover property ($rose(fl_reset_n));
endmodule

bind fsrp_host fsrp_host_chk #(.PROT_CYC(PROT_CYC), .UNPR_CYC(UNPR_CYC)) u_chk (
  .clk, .rstn, .wb_cyc, .wb_stb, .wb_ack, .fl_addr, .fl_dq_oe_n, .fl_ce_n, .fl_oe_n, .fl_we_n,
  .fl_reset_n, .fl_a9_hv_en, .fl_oe_hv_en
);

// [testbench/fsrp_host_test.sv]
`timescale 1ns/1ps
module fsrp_host_test;
  import fsrp_pkg::*;
  logic        clk = 1'b0, rstn = 1'b0, wb_cyc = 1'b0, wb_stb = 1'b0, wb_we = 1'b0, supply_ok = 1'b1;
  logic [7:0]  wb_adr = 8'h00;
  logic [3:0]  wb_sel = 4'hf;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd, st;
  logic        wb_ack, fl_dq_oe_n, fl_ce_n, fl_oe_n, fl_we_n, fl_reset_n, fl_a9_hv_en, fl_oe_hv_en;
  logic        fl_rst_hv_en, fl_ready_busy;
  logic [19:0] fl_addr;
  logic [7:0]  fl_dq_o, fl_dq_i;
  int          n_errors = 0, compares = 0;
  fsrp_host #(.PROT_CYC(20), .UNPR_CYC(40)) DUT (
    .clk, .rstn, .ce(1'b1), .wb_cyc, .wb_stb, .wb_we, .wb_adr, .wb_sel, .wb_dat_i, .wb_dat_o,
    .wb_ack, .fl_addr, .fl_dq_o, .fl_dq_oe_n, .fl_dq_i, .fl_ce_n, .fl_oe_n, .fl_we_n, .fl_reset_n,
    .fl_a9_hv_en, .fl_oe_hv_en, .fl_rst_hv_en, .fl_ready_busy, .supply_ok
  );
  fsrp_flash_model #(.PROT_NS(160), .UNPR_NS(320)) FM (
    .fl_addr, .fl_dq_o, .fl_dq_oe_n, .fl_ce_n, .fl_oe_n, .fl_we_n, .fl_reset_n, .fl_a9_hv_en,
    .fl_oe_hv_en, .fl_rst_hv_en, .supply_ok, .fl_dq_i, .fl_ready_busy
  );
  initial begin
    forever #4 clk = ~clk;
  end
  task print_verdict;
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task chk(input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e) begin
      n_errors++;
      $display("mismatch at %0t: saw %h expected %h", $time, s, e);
    end
  endtask
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge clk);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= w;
    wb_adr <= a;
    wb_dat_i <= d;
    for (i = 0; i < 50; i++) begin
      @(posedge clk);
      if (wb_ack === 1'b1) break;
    end
    rd = wb_dat_o;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    if (i == 50) begin
      n_errors++;
      print_verdict;
    end
  endtask
  // polls status; the unprotect sweep is the longest wait
  task poll(input int b, input logic v);
    int i;
    for (i = 0; i < 20000; i++) begin
      wb(1'b0, REG_STATUS, 32'h0);
      if (rd[b] === v) break;
    end
    st = rd;
    if (i == 20000) begin
      n_errors++;
      print_verdict;
    end
  endtask
  task go(input fsrp_op_t op);
    wb(1'b1, REG_STATUS, 32'h38);
    wb(1'b1, REG_CTRL, {28'h0, op, 1'b1});
    poll(ST_CBUSY, 1'b0);
  endtask
  // a busy phase must be seen to start before its end means anything
  task settle;
    poll(ST_READY, 1'b0);
    poll(ST_READY, 1'b1);
  endtask
  task rdata(input logic [7:0] e);
    wb(1'b0, REG_RDATA, 32'h0);
    chk(rd, {24'h0, e});
  endtask
  task t_regs;
    wb(1'b0, REG_MODE, 32'h0);
    chk(rd, {16'h0, SUSP_RST, 8'h00});
    wb_sel <= 4'h2;
    wb(1'b1, REG_ADDR, 32'h000fcd77);
    wb_sel <= 4'hf;
    wb(1'b0, REG_ADDR, 32'h0);
    chk(rd, 32'h0000cd00);
    wb(1'b0, 8'h1c, 32'h0);
    chk(rd, 32'h0);
    wb(1'b0, REG_STATUS, 32'h0);
    chk(rd[ST_READY], 1'b1);
  endtask
  task t_busy;
    wb(1'b1, REG_ADDR, 32'h12345);
    wb(1'b1, REG_WDATA, 32'h5a);
    go(OP_WRITE);
    chk(st[ST_DONE], 1'b1);
    go(OP_WRITE);
    chk(st[ST_REFUSED], 1'b1);
    wb(1'b1, REG_WDATA, {24'h0, SUSP_RST});
    go(OP_WRITE);
    chk(st[ST_REFUSED], 1'b0);
    chk(st[ST_READY], 1'b1);
    wb(1'b1, REG_WDATA, 32'h5a);
    go(OP_WRITE);
    go(OP_RESET);
    chk(st[ST_REWRITE], 1'b1);
    chk(st[ST_READY], 1'b1);
    go(OP_READ);
    rdata(8'h5a);
  endtask
  task t_prot;
    wb(1'b1, REG_ADDR, {12'h0, 7'h09, 13'h0});
    go(OP_PROTECT);
    go(OP_VPROT);
    rdata(PROT_YES);
    chk(st[ST_PROT], 1'b1);
    wb(1'b1, REG_ADDR, {12'h0, 7'h09, 13'h10});
    wb(1'b1, REG_WDATA, 32'h77);
    go(OP_WRITE);
    settle;
    go(OP_READ);
    rdata(8'hff);
    wb(1'b1, REG_MODE, {16'h0, SUSP_RST, 8'h02});
    go(OP_WRITE);
    settle;
    go(OP_READ);
    rdata(8'h77);
    wb(1'b1, REG_MODE, {16'h0, SUSP_RST, 8'h00});
    go(OP_VUNPROT);
    rdata(PROT_YES);
  endtask
  task t_unpr;
    poll(ST_READY, 1'b1);
    go(OP_UNPROT);
    go(OP_VUNPROT);
    rdata(8'h00);
    go(OP_VPROT);
    rdata(8'h00);
  endtask
  task t_lock;
    supply_ok <= 1'b0;
    go(OP_WRITE);
    chk(st[ST_SUPPLY], 1'b0);
    chk(st[ST_REFUSED], 1'b1);
    supply_ok <= 1'b1;
  endtask
  task t_pdown;
    wb(1'b1, REG_MODE, {16'h0, SUSP_RST, 8'h01});
    wb(1'b0, REG_MODE, 32'h0);
    chk(fl_reset_n, 1'b0);
    go(OP_READ);
    chk(st[ST_REFUSED], 1'b1);
    wb(1'b1, REG_MODE, {16'h0, SUSP_RST, 8'h00});
    wb(1'b1, REG_ADDR, 32'h12345);
    go(OP_RESET);
    chk(st[ST_REWRITE], 1'b0);
    go(OP_READ);
    rdata(8'h5a);
  endtask
  initial begin
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    repeat (3) @(posedge clk);
    t_regs;
    t_busy;
    t_prot;
    t_unpr;
    t_lock;
    t_pdown;
    print_verdict;
  end
endmodule
